// File: rtl/tbid_defs.vh
// Purpose: Constants for the twelve-bit instruction decoder.
// Assumes: Plain Verilog-2005, included by bare name.
// Notes: Opcode encodings, field positions and timing counts.
`ifndef TBID_DEFS_VH
`define TBID_DEFS_VH

`define TBID_IW              12
`define TBID_FILE_LO         0
`define TBID_FILE_HI         4
`define TBID_FILE_ADDR_W     7
`define TBID_FILE_ADDR_MAX   7'h7f
`define TBID_DEST_BIT        5
`define TBID_BIT_LO          5
`define TBID_BIT_HI          7
`define TBID_LIT8_HI         7
`define TBID_LIT9_HI         8
`define TBID_TRIS_HI         2
`define TBID_PC_W            9
`define TBID_PC_BIT9         8

`define TBID_CLASS_BYTE      2'h0
`define TBID_CLASS_BIT       2'h1
`define TBID_CLASS_LIT       2'h2

// Operation codes presented to the datapath.
`define TBID_OP_NOP          5'h00
`define TBID_OP_MOVWF        5'h01
`define TBID_OP_CLRW         5'h02
`define TBID_OP_CLRF         5'h03
`define TBID_OP_SUBWF        5'h04
`define TBID_OP_DECF         5'h05
`define TBID_OP_IORWF        5'h06
`define TBID_OP_ANDWF        5'h07
`define TBID_OP_XORWF        5'h08
`define TBID_OP_ADDWF        5'h09
`define TBID_OP_MOVF         5'h0a
`define TBID_OP_COMF         5'h0b
`define TBID_OP_INCF         5'h0c
`define TBID_OP_DECFSZ       5'h0d
`define TBID_OP_RRF          5'h0e
`define TBID_OP_RLF          5'h0f
`define TBID_OP_SWAPF        5'h10
`define TBID_OP_INCFSZ       5'h11
`define TBID_OP_BCF          5'h12
`define TBID_OP_BSF          5'h13
`define TBID_OP_BTSKIPCLR    5'h14
`define TBID_OP_BTSKIPSET    5'h15
`define TBID_OP_RETLW        5'h16
`define TBID_OP_CALL         5'h17
`define TBID_OP_GOTO         5'h18
`define TBID_OP_MOVLW        5'h19
`define TBID_OP_IORLW        5'h1a
`define TBID_OP_ANDLW        5'h1b
`define TBID_OP_XORLW        5'h1c
`define TBID_OP_OPTION       5'h1d
`define TBID_OP_SLEEP        5'h1e
`define TBID_OP_TRIS         5'h1f
`define TBID_OP_CLRTIMER     5'h01

`define TBID_NIB_BTSKIPCLR   4'h6

// One instruction cycle is this many oscillator periods.
`define TBID_PHASES          4
`define TBID_PH_W            2
`define TBID_PH_LAST         2'h3
`define TBID_PH_FIRST        2'h0

`endif

// File: rtl/tbid_phase.v
// Purpose: Quarter-cycle phase counter for the instruction cycle.
// Assumes: Clock is the core oscillator.
// Notes: cycle_end pulses on the last oscillator period of each cycle.
`timescale 1ns/100ps
`include "tbid_defs.vh"

module tbid_phase (
	input  wire                    clock,
	input  wire                    rst_n,
	output reg  [`TBID_PH_W-1:0]   phase,
	output reg                     cycle_end
);

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase     <= `TBID_PH_FIRST;
			cycle_end <= 1'b0;
		end else begin
			phase     <= phase + 2'h1;
			cycle_end <= (phase == (`TBID_PH_LAST - 2'h1));
		end
	end

endmodule

// File: rtl/tbid_field.v
// Purpose: Combinational split of a 12-bit word into class, operation and fields.
// Assumes: Word is stable while decoded.
// Notes: Don't-care bits are never examined.
`timescale 1ns/100ps
`include "tbid_defs.vh"

module tbid_field (
	input  wire [`TBID_IW-1:0]           word,
	output reg  [1:0]                    op_class,
	output reg  [4:0]                    op_code,
	output wire [`TBID_FILE_ADDR_W-1:0]  file_addr,
	output wire                          dest_file,
	output wire [2:0]                    bit_sel,
	output reg  [`TBID_LIT9_HI:0]        literal,
	output reg                           changes_pc,
	output reg                           is_skip,
	output reg                           valid
);

	// Five-bit file field, zero-extended into the 0x00..0x7F address space.
	assign file_addr = {2'h0, word[`TBID_FILE_HI:`TBID_FILE_LO]};
	assign dest_file = word[`TBID_DEST_BIT];
	assign bit_sel   = word[`TBID_BIT_HI:`TBID_BIT_LO];

	always @* begin
		op_class   = `TBID_CLASS_LIT;
		op_code    = `TBID_OP_NOP;
		literal    = {1'b0, word[`TBID_LIT8_HI:0]};
		changes_pc = 1'b0;
		is_skip    = 1'b0;
		valid      = 1'b1;
		case (word[11:10])
		2'h0: begin
			op_class = `TBID_CLASS_BYTE;
			case (word[9:6])
			4'h0: begin
				if (word[5]) begin
					op_code = `TBID_OP_MOVWF;
				end else begin
					// The 0000 0000 group carries no file operand.
					op_class = `TBID_CLASS_LIT;
					literal  = {6'h00, word[`TBID_TRIS_HI:0]};
					if (word[4:3] != 2'h0) begin
						valid = 1'b0;
					end else begin
						case (word[2:0])
						3'h0: op_code = `TBID_OP_NOP;
						3'h2: op_code = `TBID_OP_OPTION;
						3'h3: op_code = `TBID_OP_SLEEP;
						3'h4: op_code = `TBID_OP_CLRTIMER;
						3'h5, 3'h6, 3'h7: op_code = `TBID_OP_TRIS;
						default: valid = 1'b0;
						endcase
					end
				end
			end
			// Low bits of CLRW are don't-care.
			4'h1: op_code = word[5] ? `TBID_OP_CLRF : `TBID_OP_CLRW;
			4'h2: op_code = `TBID_OP_SUBWF;
			4'h3: op_code = `TBID_OP_DECF;
			4'h4: op_code = `TBID_OP_IORWF;
			4'h5: op_code = `TBID_OP_ANDWF;
			4'h6: op_code = `TBID_OP_XORWF;
			4'h7: op_code = `TBID_OP_ADDWF;
			4'h8: op_code = `TBID_OP_MOVF;
			4'h9: op_code = `TBID_OP_COMF;
			4'ha: op_code = `TBID_OP_INCF;
			4'hb: begin
				op_code = `TBID_OP_DECFSZ;
				is_skip = 1'b1;
			end
			4'hc: op_code = `TBID_OP_RRF;
			4'hd: op_code = `TBID_OP_RLF;
			4'he: op_code = `TBID_OP_SWAPF;
			default: begin
				op_code = `TBID_OP_INCFSZ;
				is_skip = 1'b1;
			end
			endcase
		end
		2'h1: begin
			op_class = `TBID_CLASS_BIT;
			case (word[9:8])
			2'h0: op_code = `TBID_OP_BCF;
			2'h1: op_code = `TBID_OP_BSF;
			2'h2: begin
				op_code = `TBID_OP_BTSKIPCLR;
				is_skip = 1'b1;
			end
			default: begin
				op_code = `TBID_OP_BTSKIPSET;
				is_skip = 1'b1;
			end
			endcase
		end
		2'h2: begin
			changes_pc = 1'b1;
			case (word[9:8])
			2'h0: op_code = `TBID_OP_RETLW;
			2'h1: op_code = `TBID_OP_CALL;
			default: begin
				op_code = `TBID_OP_GOTO;
				literal = word[`TBID_LIT9_HI:0];
			end
			endcase
		end
		default: begin
			case (word[9:8])
			2'h0: op_code = `TBID_OP_MOVLW;
			2'h1: op_code = `TBID_OP_IORLW;
			2'h2: op_code = `TBID_OP_ANDLW;
			default: op_code = `TBID_OP_XORLW;
			endcase
		end
		endcase
	end

endmodule

// File: rtl/tbid_decoder.v
// Purpose: Twelve-bit instruction decoder with instruction-cycle timing.
// Assumes: Program memory presents the fetched word with fetch_valid at cycle end.
// Notes: Decode outputs are registered once per instruction cycle; cycle_end every clock, pc_load and flush clear the next clock.
`timescale 1ns/100ps
`include "tbid_defs.vh"

module tbid_decoder (
	input  wire                          clock,
	input  wire                          rst_n,
	input  wire [`TBID_IW-1:0]           fetch_word,
	input  wire                          fetch_valid,
	input  wire                          skip_true,
	output reg  [1:0]                    op_class,
	output reg  [4:0]                    op_code,
	output reg  [`TBID_FILE_ADDR_W-1:0]  file_addr,
	output reg                           dest_file,
	output reg                           dest_accum,
	output reg  [7:0]                    bit_mask,
	output reg  [`TBID_LIT9_HI:0]        literal,
	output reg                           pc_load,
	output reg  [`TBID_PC_W-1:0]         pc_target,
	output reg                           exec_valid,
	output reg                           flush,
	output reg                           second_cycle,
	output reg                           decode_error,
	output reg                           cycle_end
);

	wire [`TBID_PH_W-1:0]           phase;
	wire                            tick;
	wire [1:0]                      f_class;
	wire [4:0]                      f_code;
	wire [`TBID_FILE_ADDR_W-1:0]    f_addr;
	wire                            f_dest;
	wire [2:0]                      f_bit;
	wire [`TBID_LIT9_HI:0]          f_lit;
	wire                            f_pc;
	wire                            f_skip;
	wire                            f_valid;
	reg                             pend_skip;
	reg                             stall;
	reg  [`TBID_PC_W-1:0]           next_pc_target;
	reg  [7:0]                      next_mask;
	wire                            take_skip;
	integer                         i;

	tbid_phase u_phase (
		.clock     (clock),
		.rst_n     (rst_n),
		.phase     (phase),
		.cycle_end (tick)
	);

	tbid_field u_field (
		.word       (fetch_word),
		.op_class   (f_class),
		.op_code    (f_code),
		.file_addr  (f_addr),
		.dest_file  (f_dest),
		.bit_sel    (f_bit),
		.literal    (f_lit),
		.changes_pc (f_pc),
		.is_skip    (f_skip),
		.valid      (f_valid)
	);

	// The datapath reports the test outcome of the skip issued last cycle.
	assign take_skip = pend_skip & skip_true;

	always @* begin
		next_pc_target = f_lit;
		if (f_code != `TBID_OP_GOTO) begin
			next_pc_target[`TBID_PC_BIT9] = 1'b0;
		end
		next_mask = 8'h00;
		for (i = 0; i < 8; i = i + 1) begin
			if (f_bit == i[2:0]) begin
				next_mask[i] = 1'b1;
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op_class     <= `TBID_CLASS_LIT;
			op_code      <= `TBID_OP_NOP;
			file_addr    <= 7'h00;
			dest_file    <= 1'b0;
			dest_accum   <= 1'b0;
			bit_mask     <= 8'h00;
			literal      <= 9'h000;
			pc_load      <= 1'b0;
			pc_target    <= 9'h000;
			exec_valid   <= 1'b0;
			flush        <= 1'b0;
			second_cycle <= 1'b0;
			decode_error <= 1'b0;
			cycle_end    <= 1'b0;
			pend_skip    <= 1'b0;
			stall        <= 1'b0;
		end else begin
			cycle_end <= tick;
			if (tick) begin
				if (stall || take_skip || !fetch_valid) begin
					// Second cycle or invalid fetch: the fetched word is not issued.
					op_class     <= `TBID_CLASS_LIT;
					op_code      <= `TBID_OP_NOP;
					dest_file    <= 1'b0;
					dest_accum   <= 1'b0;
					bit_mask     <= 8'h00;
					pc_load      <= 1'b0;
					exec_valid   <= 1'b0;
					flush        <= stall | take_skip;
					second_cycle <= stall | take_skip;
					decode_error <= 1'b0;
					pend_skip    <= 1'b0;
					stall        <= 1'b0;
				end else begin
					op_class     <= f_class;
					op_code      <= f_code;
					file_addr    <= f_addr;
					dest_file    <= (f_class == `TBID_CLASS_BYTE) & f_dest;
					dest_accum   <= (f_class == `TBID_CLASS_BYTE) & ~f_dest;
					bit_mask     <= (f_class == `TBID_CLASS_BIT) ? next_mask : 8'h00;
					literal      <= f_lit;
					pc_load      <= f_pc;
					pc_target    <= next_pc_target;
					exec_valid   <= f_valid;
					flush        <= 1'b0;
					second_cycle <= 1'b0;
					decode_error <= ~f_valid;
					pend_skip    <= f_skip & f_valid;
					stall        <= f_pc & f_valid;
				end
			end else begin
				pc_load <= 1'b0;
				flush   <= 1'b0;
			end
		end
	end

endmodule

// File: sim/tbid_monitor.sv
// Purpose: Port checker for the twelve-bit instruction decoder.
// Assumes: Bound to tbid_decoder; one clock domain.
// Notes: Field checks are qualified by exec_valid at cycle end.
`timescale 1ns/100ps
`include "tbid_defs.vh"
module tbid_monitor (
	input wire                          clock,
	input wire                          rst_n,
	input wire [`TBID_IW-1:0]           fetch_word,
	input wire [1:0]                    op_class,
	input wire [4:0]                    op_code,
	input wire [`TBID_FILE_ADDR_W-1:0]  file_addr,
	input wire                          dest_file,
	input wire                          dest_accum,
	input wire [7:0]                    bit_mask,
	input wire [`TBID_LIT9_HI:0]        literal,
	input wire                          pc_load,
	input wire [`TBID_PC_W-1:0]         pc_target,
	input wire                          exec_valid,
	input wire                          flush,
	input wire                          second_cycle,
	input wire                          cycle_end
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_cycle_period: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
		else $error("cycle_end spacing wrong");
	a_branch_flush: assert property (pc_load |-> ##4 (flush && second_cycle && !exec_valid))
		else $error("no discarded cycle after pc write");
	a_pc_high_clear: assert property (pc_load && op_code != `TBID_OP_GOTO |-> !pc_target[8])
		else $error("pc target high bit not cleared");
	a_decode_hold: assert property (!cycle_end |-> $stable(op_code) && $stable(file_addr))
		else $error("decode changed mid cycle");
	a_skip_clear: assert property (cycle_end && exec_valid && $past(fetch_word[11:8]) == `TBID_NIB_BTSKIPCLR |-> op_code == `TBID_OP_BTSKIPCLR && bit_mask == (8'h01 << $past(fetch_word[7:5])))
		else $error("bit test skip clear misdecoded");
	a_dest_steer: assert property (cycle_end && exec_valid && op_class == `TBID_CLASS_BYTE |-> dest_file == $past(fetch_word[5]) && dest_accum != dest_file)
		else $error("destination select wrong");
	a_file_field: assert property (cycle_end && exec_valid && op_class != `TBID_CLASS_LIT |-> file_addr == {2'h0, $past(fetch_word[4:0])})
		else $error("file address wrong");
	a_lit_field: assert property (cycle_end && exec_valid && $past(fetch_word[11:10]) == 2'h3 |-> literal == {1'h0, $past(fetch_word[7:0])})
		else $error("literal wrong");
	a_class_bit: assert property (cycle_end && exec_valid |-> (op_class == `TBID_CLASS_BIT) == ($past(fetch_word[11:10]) == 2'h1))
		else $error("bit class wrong");
endmodule

// File: sim/tbid_pmem.sv
// Purpose: Program memory model presenting one word per instruction cycle.
// Assumes: Bench supplies next_word and next_valid before the load edge.
// Notes: A low next_valid models a slow fetch.
`timescale 1ns/100ps
module tbid_pmem (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        cycle_end,
	input  wire [11:0] next_word,
	input  wire        next_valid,
	output reg  [11:0] fetch_word,
	output reg         fetch_valid
);
	reg load;
	// The word changes two clocks after cycle_end rises and holds until the next tick.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			load <= 1'b0;
			fetch_word <= 12'h000;
			fetch_valid <= 1'b0;
		end else begin
			load <= cycle_end;
			if (load) begin
				fetch_word <= next_word;
				fetch_valid <= next_valid;
			end
		end
	end
endmodule

// File: sim/twelve_bit_instruction_decode_tb.sv
// Purpose: Self-checking bench for the twelve-bit instruction decoder.
// Assumes: Words reach the decoder through the program memory model.
// Notes: Corner words first, then random words from a fixed seed.
`timescale 1ns/100ps
`include "tbid_defs.vh"
module twelve_bit_instruction_decode_tb;
	reg         clock, rst_n, skip_true, next_valid, pend, pskip;
	reg  [11:0] next_word;
	reg  [31:0] rw;
	wire [11:0] fetch_word;
	wire        fetch_valid, dest_file, dest_accum, pc_load, exec_valid;
	wire        flush, second_cycle, decode_error, cycle_end;
	wire [1:0]  op_class;
	wire [4:0]  op_code;
	wire [6:0]  file_addr;
	wire [7:0]  bit_mask;
	wire [8:0]  literal, pc_target;
	integer     n_fail, checks, seed, cyc, i;
	tbid_pmem mem_u (.clock(clock), .rst_n(rst_n), .cycle_end(cycle_end),
		.next_word(next_word), .next_valid(next_valid), .fetch_word(fetch_word),
		.fetch_valid(fetch_valid));
	tbid_decoder dut_u (.clock(clock), .rst_n(rst_n), .fetch_word(fetch_word),
		.fetch_valid(fetch_valid), .skip_true(skip_true), .op_class(op_class),
		.op_code(op_code), .file_addr(file_addr), .dest_file(dest_file),
		.dest_accum(dest_accum), .bit_mask(bit_mask), .literal(literal), .pc_load(pc_load),
		.pc_target(pc_target), .exec_valid(exec_valid), .flush(flush),
		.second_cycle(second_cycle), .decode_error(decode_error), .cycle_end(cycle_end));
	function [1:0] e_class(input [11:0] w);
		e_class = w[11] ? `TBID_CLASS_LIT : w[10] ? `TBID_CLASS_BIT :
			(w[9:5] != 5'h00) ? `TBID_CLASS_BYTE : `TBID_CLASS_LIT;
	endfunction
	function e_skip(input [11:0] w);
		e_skip = w[11:9] == 3'h3 || w[11:6] == 6'h0b || w[11:6] == 6'h0f;
	endfunction
	function [4:0] e_code(input [11:0] w);
		begin
			case (w[11:6])
			6'h00: e_code = w[5] ? `TBID_OP_MOVWF : (w[4:3] != 2'h0) ? `TBID_OP_NOP :
				(w[2:0] == 3'h2) ? `TBID_OP_OPTION : (w[2:0] == 3'h3) ? `TBID_OP_SLEEP :
				(w[2:0] == 3'h4) ? `TBID_OP_CLRTIMER :
				(w[2:0] > 3'h4) ? `TBID_OP_TRIS : `TBID_OP_NOP;
			6'h01: e_code = w[5] ? `TBID_OP_CLRF : `TBID_OP_CLRW;
			6'h02: e_code = `TBID_OP_SUBWF;
			6'h03: e_code = `TBID_OP_DECF;
			6'h04: e_code = `TBID_OP_IORWF;
			6'h05: e_code = `TBID_OP_ANDWF;
			6'h06: e_code = `TBID_OP_XORWF;
			6'h07: e_code = `TBID_OP_ADDWF;
			6'h08: e_code = `TBID_OP_MOVF;
			6'h09: e_code = `TBID_OP_COMF;
			6'h0a: e_code = `TBID_OP_INCF;
			6'h0b: e_code = `TBID_OP_DECFSZ;
			6'h0c: e_code = `TBID_OP_RRF;
			6'h0d: e_code = `TBID_OP_RLF;
			6'h0e: e_code = `TBID_OP_SWAPF;
			6'h0f: e_code = `TBID_OP_INCFSZ;
			default: begin
				case (w[11:8])
				4'h4: e_code = `TBID_OP_BCF;
				4'h5: e_code = `TBID_OP_BSF;
				4'h6: e_code = `TBID_OP_BTSKIPCLR;
				4'h7: e_code = `TBID_OP_BTSKIPSET;
				4'h8: e_code = `TBID_OP_RETLW;
				4'h9: e_code = `TBID_OP_CALL;
				4'ha, 4'hb: e_code = `TBID_OP_GOTO;
				4'hc: e_code = `TBID_OP_MOVLW;
				4'hd: e_code = `TBID_OP_IORLW;
				4'he: e_code = `TBID_OP_ANDLW;
				default: e_code = `TBID_OP_XORLW;
				endcase
			end
			endcase
		end
	endfunction
	task chk(input [8*8-1:0] nm, input [11:0] e, input [11:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d n_fail %0d", checks, n_fail);
			if (n_fail == 0 && checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Argument s is the skip outcome of the previously issued instruction.
	task run1(input [11:0] w, input v, input s);
		integer   n;
		reg       fl;
		reg [1:0] ec;
		reg [8:0] el;
		reg       ee;
		begin
			fl = pend || (pskip && s);
			ec = e_class(w);
			ee = (w[11:5] == 7'h00) && (w[4:3] != 2'h0 || w[2:0] == 3'h1);
			el = (w[11:9] == 3'h5) ? w[8:0] : {1'b0, w[7:0]};
			@(posedge clock);
			next_word <= w;
			next_valid <= v || fl;
			skip_true <= s;
			n = 1;
			do begin
				@(posedge clock);
				#1;
				n = n + 1;
			end while (!cycle_end && n < 9);
			chk("cyc_len", 4, n);
			if (fl) begin
				chk("flush", 1, flush);
				chk("second", 1, second_cycle);
				chk("exec", 0, exec_valid);
				chk("pc_load", 0, pc_load);
				pend = 0;
				pskip = 0;
			end else if (!v) begin
				chk("exec", 0, exec_valid);
				chk("flush", 0, flush);
				pskip = 0;
			end else begin
				chk("class", ec, op_class);
				chk("op_code", e_code(w), op_code);
				chk("exec", !ee, exec_valid);
				chk("dec_err", ee, decode_error);
				chk("pc_load", w[11:10] == 2'h2, pc_load);
				if (w >= 12'h020) begin
					if (ec != `TBID_CLASS_LIT)
						chk("file", {2'h0, w[4:0]}, file_addr);
					if (ec == `TBID_CLASS_BYTE)
						chk("dest", w[5], dest_file);
					chk("accum", ec == `TBID_CLASS_BYTE && !w[5], dest_accum);
					chk("mask", (ec == `TBID_CLASS_BIT) ? 8'h01 << w[7:5] : 8'h00, bit_mask);
					if (w[11])
						chk("literal", el, literal);
					if (w[11:10] == 2'h2)
						chk("target", el, pc_target);
				end
				pend = w[11:10] == 2'h2;
				pskip = e_skip(w);
			end
		end
	endtask
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			n_fail = n_fail + 1;
			tally_and_finish;
		end
	end
	initial begin
		rst_n = 0;
		next_word = 12'h000;
		next_valid = 0;
		skip_true = 0;
		pend = 0;
		pskip = 0;
		n_fail = 0;
		checks = 0;
		cyc = 0;
		seed = 7;
		repeat (5) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		#1;
		while (!cycle_end) begin
			@(posedge clock);
			#1;
		end
		run1(12'hb05, 1, 0);
		run1(12'h123, 1, 0);
		run1(12'h925, 1, 0);
		run1(12'h456, 1, 0);
		run1(12'h8aa, 1, 0);
		run1(12'hbff, 1, 0);
		run1(12'h6e3, 1, 0);
		run1(12'h1ff, 1, 1);
		run1(12'h7a0, 1, 0);
		run1(12'h0c0, 1, 0);
		run1(12'h03f, 0, 0);
		run1(12'h3df, 1, 0);
		run1(12'hcff, 1, 1);
		run1(12'he5a, 1, 0);
		run1(12'h04a, 1, 0);
		run1(12'h006, 1, 0);
		run1(12'h001, 1, 0);
		$display("test corner done");
		for (i = 0; i < 48; i = i + 1) begin
			rw = $random(seed);
			run1(rw[11:0], rw[14:12] != 3'h0, rw[15]);
		end
		$display("test random done");
		tally_and_finish;
	end
endmodule
bind tbid_decoder tbid_monitor mon_u (.clock(clock), .rst_n(rst_n), .fetch_word(fetch_word),
	.op_class(op_class), .op_code(op_code), .file_addr(file_addr), .dest_file(dest_file),
	.dest_accum(dest_accum), .bit_mask(bit_mask), .literal(literal), .pc_load(pc_load),
	.pc_target(pc_target), .exec_valid(exec_valid), .flush(flush),
	.second_cycle(second_cycle), .cycle_end(cycle_end));
